// [dv/smt_bus_peer.sv]
// Far-side bus peer: pull-ups, clock stretching, peer clock frames
module smt_bus_peer (
  // Device enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Peer controls
  input wire logic stretch,
  input wire logic frame,
  // Wire levels
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic p_scl = 1'b0; // Peer clock pulls low
  logic s_scl = 1'b0; // Stretch pulls low
  // Peer clock runs only within frames
  always begin
    #160 p_scl = frame && !p_scl;
  end
  // Slow slave holds SCL low after release
  always @(negedge scl_oe) begin
    if (stretch) begin
      s_scl = 1'b1;
      #600 s_scl = 1'b0;
    end
  end
  // Open-drain wires with pull-ups
  assign scl = !(scl_oe || p_scl || s_scl);
  assign sda = !sda_oe;
endmodule : smt_bus_peer

// [dv/smt_timing_properties.sv]
// Port-level checks for the SMBus timing block
module smt_timing_properties
  import smt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_rdata,
  // Events and pins
  input wire logic scl_in,
  input wire logic t3_reload,
  input wire logic free_stop,
  input wire logic start_go,
  input wire logic slave_active,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Lone write to the config address
  sequence cfg_wr_s;
    sfr_wr && sfr_addr == SMT_CFG_ADDR ##1 !sfr_wr;
  endsequence
  a_cfg_write: assert property (cfg_wr_s |=>
    sfr_rdata[4:0] == $past(sfr_wdata[4:0], 2)) else $error("cfg lost");
  a_reload_high: assert property (
    (sfr_rdata[SMT_B_TOE] && scl_in) [*5] |-> t3_reload)
    else $error("no reload while SCL high");
  a_reload_low: assert property (
    (sfr_rdata[SMT_B_TOE] && !scl_in) [*5] |-> !t3_reload)
    else $error("reload while SCL low");
  a_free_fte: assert property (free_stop |-> sfr_rdata[SMT_B_FTE])
    else $error("free timeout while disabled");
  a_start_free: assert property ($rose(start_go) |->
    free_stop || $past(free_stop)) else $error("start without free");
  a_pins_low: assert property (!(scl_out || sda_out))
    else $error("pin driven high");
  a_hold_std: assert property (
    $rose(scl_oe) |-> $stable(sda_oe) [*3])
    else $error("short hold");
  a_hold_ext: assert property (
    $rose(scl_oe) && sfr_rdata[SMT_B_SDA_HOLD_EXTEND] |->
    $stable(sda_oe) [*8] ##1 $stable(sda_oe) [*4])
    else $error("short extended hold");
  a_slave_off: assert property (
    (!sfr_rdata[SMT_B_ENABLE]) [*2] |-> !slave_active)
    else $error("slave active while off");
endmodule : smt_timing_properties

bind smt_timing smt_timing_properties u_props (.sys_clk, .rst, .sfr_addr,
  .sfr_wdata, .sfr_wr, .sfr_rdata, .scl_in, .t3_reload, .free_stop,
  .start_go, .slave_active, .scl_out, .sda_out, .scl_oe, .sda_oe);

// [dv/smt_timing_tb_top.sv]
// Self-checking bench for the SMBus timing block
module smt_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import smt_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0;
  logic dwr = 1'b0, fclr = 1'b0, stp = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd;
  smt_ovf_t ovf = '0;
  logic master = 1'b0, rel = 1'b0, sbit = 1'b0, req = 1'b0, sst = 1'b0;
  logic stretch = 1'b0, frame = 1'b0, scl, sda, rl, fs, sg, sa;
  logic scl_oe, sda_oe, p_oe = 1'b0;
  int err_count = 0, tests_run = 0, cyc = 0;
  int nfs = 0, nsg = 0, nlo = 0, nhi = 0, nbit = 0;
  smt_timing uut (.sys_clk, .rst, .sfr_addr(addr), .sfr_wdata(wd),
    .sfr_wr(wr), .sfr_rdata(rd), .tmr_ovf(ovf), .t3_reload(rl),
    .seq_master(master), .seq_scl_release(rel), .seq_sda_bit(sbit),
    .seq_data_wr(dwr), .seq_flag_clear(fclr), .seq_start_req(req),
    .seq_start_seen(sst), .seq_stop_seen(stp), .free_stop(fs),
    .start_go(sg), .slave_active(sa), .scl_in(scl), .sda_in(sda),
    .scl_out(), .scl_oe, .sda_out(), .sda_oe);
  smt_bus_peer peer (.scl_oe, .sda_oe, .stretch, .frame, .scl, .sda);
  initial forever #20 sys_clk = ~sys_clk;
  // Event counters and run ceiling
  always @(posedge sys_clk) begin
    cyc++;
    nfs += (fs === 1'b1);
    nsg += (sg === 1'b1);
    nlo += (scl_oe === 1'b1);
    nhi += (scl_oe === 1'b0);
    nbit += (scl_oe === 1'b1 && !p_oe);
    p_oe = scl_oe;
    if (cyc == 30000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_cfg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge sys_clk);
    wr = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : wr_cfg
  // Free-running overflow of source k, one every gap + 1 clocks
  task automatic tick(input int k, input int n, input int gap = 7);
    repeat (n) begin
      ovf[3-k] = 1'b1;
      sbit = ~sbit;
      @(negedge sys_clk);
      ovf = '0;
      repeat (gap) @(negedge sys_clk);
    end
  endtask : tick
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    chk(rd, SMT_CFG_RESET);
    wr_cfg(SMT_CFG_ADDR, 8'h7F);
    chk(rd, 8'h5F);
    wr_cfg(8'hC0, 8'h00);
    chk(rd, 8'h5F);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      wr_cfg(SMT_CFG_ADDR, 8'h00);
      wr_cfg(SMT_CFG_ADDR, 8'h84 | 8'(s));
      nfs = 0;
      nsg = 0;
      tick((s + 1) % 4, 12);
      tick(s, 9);
      chk(8'(nfs), 8'h00);
      req = 1'b1;
      tick(s, 3);
      req = 1'b0;
      chk(8'(nfs), 8'h01);
      chk(8'(nsg), 8'h01);
    end
    wr_cfg(SMT_CFG_ADDR, 8'h80);
    nfs = 0;
    tick(0, 14);
    chk(8'(nfs), 8'h00);
    $display("test free timeout done");
    chk({7'h00, sa}, 8'h01);
    wr_cfg(SMT_CFG_ADDR, 8'hC0);
    chk({7'h00, sa}, 8'h01);
    sst = 1'b1;
    @(negedge sys_clk);
    sst = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({7'h00, sa}, 8'h00);
    chk(rd, 8'hE0);
    stp = 1'b1;
    @(negedge sys_clk);
    stp = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(rd, 8'hC0);
    $display("test inhibit done");
    wr_cfg(SMT_CFG_ADDR, 8'h88);
    master = 1'b1;
    rel = 1'b1;
    tick(0, 3);
    {nlo, nhi, nbit} = '0;
    tick(0, 24);
    chk(8'(nbit >= 7 && nbit <= 9), 8'h01);
    chk(8'(nhi > nlo + nlo / 2 && nlo >= 7 * 8), 8'h01);
    // Pending flag stalls the release, a data write restarts setup
    fclr = 1'b1;
    tick(0, 4);
    dwr = 1'b1;
    @(negedge sys_clk);
    dwr = 1'b0;
    tick(0, 2);
    chk({7'h00, scl_oe}, 8'h01);
    fclr = 1'b0;
    // Slow slave stretches every low phase
    stretch = 1'b1;
    tick(0, 3);
    nbit = 0;
    tick(0, 24);
    chk(8'(nbit >= 3 && nbit < 7), 8'h01);
    stretch = 1'b0;
    // Extended timing only with a bus clock below 100 kHz
    wr_cfg(SMT_CFG_ADDR, 8'h98);
    tick(0, 3, 99);
    nbit = 0;
    tick(0, 24, 99);
    chk(8'(nbit >= 7 && nbit <= 9), 8'h01);
    {master, rel, stretch} = '0;
    $display("test master clock done");
    frame = 1'b1;
    @(negedge scl);
    repeat (4) @(negedge sys_clk);
    chk({7'h00, rl}, 8'h00);
    repeat (64) @(negedge sys_clk);
    frame = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk({7'h00, rl}, 8'h01);
    $display("test link frame done");
    complete_run();
  end
endmodule : smt_timing_tb_top

// [hdl/smt_pkg.sv]
// Package: register layout, timing counts and carriers for the SMBus timing block
package smt_pkg;

  // Register address and reset value
  localparam logic [7:0] SMT_CFG_ADDR = 8'hC1;
  localparam logic [7:0] SMT_CFG_RESET = 8'h00;

  // Field positions in the configuration register
  localparam int SMT_B_ENABLE = 7;
  localparam int SMT_B_INHIBIT = 6;
  localparam int SMT_B_BUSY = 5;
  localparam int SMT_B_SDA_HOLD_EXTEND = 4;
  localparam int SMT_B_TOE = 3;
  localparam int SMT_B_FTE = 2;

  // Clock source select codes
  localparam logic [1:0] SMT_SRC_T0 = 2'h0;
  localparam logic [1:0] SMT_SRC_T1 = 2'h1;
  localparam logic [1:0] SMT_SRC_T2H = 2'h2;
  localparam logic [1:0] SMT_SRC_T2L = 2'h3;

  // SDA timing in system clocks, bus-free and SCL high counts in source overflows
  localparam logic [3:0] SMT_SETUP_EXT = 4'hB;
  localparam logic [3:0] SMT_HOLD_EXT = 4'hC;
  localparam logic [3:0] SMT_HOLD_STD = 4'h3;
  localparam logic [3:0] SMT_SETUP_STD = 4'h1;
  localparam logic [3:0] SMT_FREE_PERIODS = 4'hA;
  localparam logic [1:0] SMT_HIGH_OVF = 2'h2;

  // Configuration register fields
  typedef struct packed {
    logic iface_enable;
    logic slave_inhibit;
    logic busy;
    logic sda_hold_extend;
    logic scl_low_timeout_en;
    logic bus_free_timeout_en;
    logic clk_src_sel_hi;
    logic clk_src_sel_lo;
  } smt_cfg_t;

  // Timer overflow pulses
  typedef struct packed {
    logic t0;
    logic t1;
    logic t2h;
    logic t2l;
  } smt_ovf_t;

endpackage : smt_pkg

// [hdl/smt_sync.sv]
// Two-flop synchroniser for bus pin levels
module smt_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Raw and synchronised levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // First stage, read only by second
  logic [W-1:0] meta_q;

  // Idle bus is high, so reset to ones
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : smt_sync

// [hdl/smt_timing.sv]
// SMBus clock/config register, SCL generation, SDA timing and timeouts
module smt_timing
  import smt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  output logic [7:0] sfr_rdata,
  // Timer overflow pulses
  input wire smt_pkg::smt_ovf_t tmr_ovf,
  // Timer 3 reload force for SCL low timeout
  output logic t3_reload,
  // Byte sequencer side
  input wire logic seq_master,
  input wire logic seq_scl_release,
  input wire logic seq_sda_bit,
  input wire logic seq_data_wr,
  input wire logic seq_flag_clear,
  input wire logic seq_start_req,
  input wire logic seq_start_seen,
  input wire logic seq_stop_seen,
  output logic free_stop,
  output logic start_go,
  output logic slave_active,
  // Open-drain pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe
);

  import smt_pkg::*;

  // SCL generator states
  typedef enum logic [1:0] {
    SMT_ST_IDLE = 2'b00,
    SMT_ST_LOW = 2'b01,
    SMT_ST_HIGH = 2'b10
  } smt_state_t;

  // Registers
  smt_cfg_t cfg_q;
  logic busy_q, busy_d;
  logic inh_q;
  smt_state_t st_q, st_d;
  logic [1:0] ovf_cnt_q, ovf_cnt_d;
  logic [3:0] free_cnt_q, free_cnt_d;
  logic [3:0] hold_cnt_q;
  logic sda_pend_q, sda_val_q;
  logic [3:0] setup_cnt_q;
  logic scl_s_prev_q;

  // Synchronised pins
  logic [1:0] pins_s;
  logic scl_s, sda_s;

  smt_sync #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Decode and selection
  wire cfg_hit = sfr_wr && (sfr_addr == SMT_CFG_ADDR);
  wire [1:0] src_sel = {cfg_q.clk_src_sel_hi, cfg_q.clk_src_sel_lo};
  wire ovf_raw = (src_sel == SMT_SRC_T0) ? tmr_ovf.t0 :
                 (src_sel == SMT_SRC_T1) ? tmr_ovf.t1 :
                 (src_sel == SMT_SRC_T2H) ? tmr_ovf.t2h :
                 tmr_ovf.t2l;
  wire src_use = cfg_q.iface_enable &&
                 (seq_master || cfg_q.bus_free_timeout_en);
  wire ovf = ovf_raw && src_use;
  wire scl_fall = scl_s_prev_q && !scl_s;
  wire both_high = scl_s && sda_s;
  wire free_hit = cfg_q.bus_free_timeout_en && both_high && ovf &&
                  (free_cnt_q == SMT_FREE_PERIODS);
  wire [3:0] setup_need = cfg_q.sda_hold_extend ? SMT_SETUP_EXT :
                          SMT_SETUP_STD;
  wire [3:0] hold_need = cfg_q.sda_hold_extend ? SMT_HOLD_EXT :
                         SMT_HOLD_STD;
  wire setup_ok = !sda_pend_q && (setup_cnt_q >= setup_need);
  wire rel_ok = seq_scl_release && !seq_flag_clear;

  // Register write and busy tracking
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= SMT_CFG_RESET;
      busy_q <= 1'b0;
    end else begin
      if (cfg_hit) begin
        cfg_q <= sfr_wdata;
      end
      busy_q <= busy_d;
    end
  end

  // Busy: set by START, cleared by STOP or free timeout
  always_comb begin
    busy_d = busy_q;
    if (!cfg_q.iface_enable) begin
      busy_d = 1'b0;
    end else if (seq_start_seen) begin
      busy_d = 1'b1;
    end else if (seq_stop_seen || free_hit) begin
      busy_d = 1'b0;
    end
  end

  // Slave inhibit latched at each START
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inh_q <= 1'b0;
    end else if (seq_start_seen) begin
      inh_q <= cfg_q.slave_inhibit;
    end
  end

  // Bus-free counter of source periods with both lines high
  always_comb begin
    free_cnt_d = free_cnt_q;
    if (!both_high || !cfg_q.bus_free_timeout_en) begin
      free_cnt_d = '0;
    end else if (ovf && free_cnt_q <= SMT_FREE_PERIODS) begin
      // Run one past the limit so the timeout fires only once
      free_cnt_d = free_cnt_q + 4'h1;
    end
  end

  // SCL generator: low one overflow, high two overflows
  always_comb begin
    st_d = st_q;
    ovf_cnt_d = ovf_cnt_q;
    case (st_q)
      SMT_ST_IDLE: begin
        ovf_cnt_d = '0;
        // Master starts its own low phase, no outside pull needed
        if (seq_master && cfg_q.iface_enable) begin
          st_d = SMT_ST_LOW;
        end
      end
      SMT_ST_LOW: begin
        if (ovf && ovf_cnt_q == 2'h0) begin
          ovf_cnt_d = 2'h1;
        end
        if (ovf_cnt_q != 2'h0 && rel_ok && setup_ok) begin
          st_d = SMT_ST_HIGH;
          ovf_cnt_d = '0;
        end
      end
      SMT_ST_HIGH: begin
        if (!scl_s && ovf_cnt_q != 2'h0) begin
          st_d = SMT_ST_LOW;
          ovf_cnt_d = '0;
        end else if (scl_s && ovf) begin
          ovf_cnt_d = ovf_cnt_q + 2'h1;
          if (ovf_cnt_q + 2'h1 == SMT_HIGH_OVF) begin
            st_d = SMT_ST_LOW;
            ovf_cnt_d = '0;
          end
        end
      end
      default: begin
        st_d = SMT_ST_IDLE;
      end
    endcase
    if (!seq_master || !cfg_q.iface_enable) begin
      st_d = SMT_ST_IDLE;
    end
  end

  // State, counters and edge history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= SMT_ST_IDLE;
      ovf_cnt_q <= '0;
      free_cnt_q <= '0;
      scl_s_prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      ovf_cnt_q <= ovf_cnt_d;
      free_cnt_q <= free_cnt_d;
      scl_s_prev_q <= scl_s;
    end
  end

  // SDA hold after SCL fall, then setup count before release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_cnt_q <= '0;
      sda_pend_q <= 1'b0;
      sda_val_q <= 1'b1;
      setup_cnt_q <= '0;
    end else begin
      if (scl_fall) begin
        hold_cnt_q <= hold_need;
      end else if (hold_cnt_q != 4'h0) begin
        hold_cnt_q <= hold_cnt_q - 4'h1;
      end
      if (seq_data_wr || scl_fall) begin
        sda_pend_q <= 1'b1;
      end else if (sda_pend_q && hold_cnt_q == 4'h0) begin
        sda_pend_q <= 1'b0;
        sda_val_q <= seq_sda_bit;
      end
      if (sda_pend_q || scl_s) begin
        setup_cnt_q <= '0;
      end else if (setup_cnt_q != SMT_HOLD_EXT) begin
        setup_cnt_q <= setup_cnt_q + 4'h1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= SMT_CFG_RESET;
      t3_reload <= 1'b1;
      free_stop <= 1'b0;
      start_go <= 1'b0;
      slave_active <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sfr_rdata <= {cfg_q[7:6], busy_q, cfg_q[4:0]};
      t3_reload <= !(cfg_q.scl_low_timeout_en && !scl_s);
      free_stop <= free_hit;
      start_go <= free_hit && seq_start_req;
      slave_active <= cfg_q.iface_enable && !inh_q;
      scl_oe <= (st_d == SMT_ST_LOW);
      sda_oe <= cfg_q.iface_enable && !sda_val_q;
    end
  end

endmodule : smt_timing
